/* verilog/tbx_pkg.sv */
package tbx_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_BR_INT_ON, OP_BR_INT_OFF,
    OP_LOAD_IND, OP_LOAD_INC, OP_LOAD_DEC, OP_LOAD_DISP, OP_LOAD_DIR,
    OP_STORE_IND, OP_STORE_INC, OP_STORE_DEC, OP_STORE_DISP, OP_STORE_DIR,
    OP_PM_R0, OP_PM_RD, OP_PM_INC, OP_EPM_R0, OP_EPM_RD, OP_EPM_INC,
    OP_PUSH, OP_POP, OP_IO_SET, OP_IO_CLR,
    OP_ROT_LEFT, OP_ROT_RIGHT, OP_BIT_TO_T, OP_T_TO_BIT,
    OP_FLAG_SET, OP_FLAG_CLR, OP_BRK
  } tbx_op_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HOLD = 2'b01,
    S_FIN  = 2'b10
  } tbx_state_type;

  // Pointer pair select and low register index of the first pair
  localparam logic [1:0]  PTR_X      = 2'h0;
  localparam logic [1:0]  PTR_Y      = 2'h1;
  localparam logic [1:0]  PTR_Z      = 2'h2;
  localparam logic [4:0]  PTR_BASE   = 5'h1A;

  // Status flag positions
  localparam int          FLG_C      = 0;
  localparam int          FLG_Z      = 1;
  localparam int          FLG_N      = 2;
  localparam int          FLG_V      = 3;
  localparam int          FLG_T      = 6;
  localparam int          FLG_I      = 7;

  // Reset values
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  PEXT_RST   = 8'h00;
  localparam logic [15:0] SP_RST     = 16'h0FFF;
  localparam logic [7:0]  RF_RST     = 8'h00;

  // Cycle counts
  localparam logic [1:0]  CYC_ONE    = 2'h1;
  localparam logic [1:0]  CYC_TWO    = 2'h2;
  localparam logic [1:0]  CYC_THREE  = 2'h3;

  function automatic logic is_pm(tbx_op_type op);
    is_pm = op inside {OP_PM_R0, OP_PM_RD, OP_PM_INC, OP_EPM_R0, OP_EPM_RD, OP_EPM_INC};
  endfunction : is_pm

  function automatic logic [1:0] op_cycles(tbx_op_type op);
    if (is_pm(op)) begin
      op_cycles = CYC_THREE;
    end else if (op inside {[OP_LOAD_IND:OP_STORE_DIR], [OP_PUSH:OP_IO_CLR]}) begin
      op_cycles = CYC_TWO;
    end else begin
      op_cycles = CYC_ONE;
    end
  endfunction : op_cycles

endpackage : tbx_pkg

/* verilog/tbx_exec_if.sv */
`timescale 1ns/100ps
interface tbx_exec_if;
  tbx_pkg::tbx_op_type op;
  logic [1:0]          ptr_sel;
  logic [5:0]          disp;
  logic [15:0]         ptr_val;
  logic [7:0]          page_ext;
  logic [7:0]          flags;
  logic [7:0]          opnd;
  logic [2:0]          bit_sel;
  logic [15:0]         eff_addr;
  logic [15:0]         ptr_next;
  logic [23:0]         pm_addr;
  logic [7:0]          page_next;
  logic                ptr_wr;
  logic                page_wr;
  logic                bad_ptr;
  logic [7:0]          alu_res;
  logic [7:0]          flags_next;
  logic                res_wr;
  logic                br_take;

  modport addr_mp (input op, ptr_sel, disp, ptr_val, page_ext,
                   output eff_addr, ptr_next, pm_addr, page_next, ptr_wr, page_wr, bad_ptr);
  modport flag_mp (input op, opnd, bit_sel, flags,
                   output alu_res, flags_next, res_wr, br_take);
  modport core_mp (output op, ptr_sel, disp, ptr_val, page_ext, flags, opnd, bit_sel,
                   input eff_addr, ptr_next, pm_addr, page_next, ptr_wr, page_wr, bad_ptr,
                   alu_res, flags_next, res_wr, br_take);
endinterface : tbx_exec_if

/* verilog/tbx_addr_gen.sv */
`timescale 1ns/100ps
module tbx_addr_gen (
  // Address operands and results
  tbx_exec_if.addr_mp x
);
  logic        inc_op;
  logic        dec_op;
  logic        disp_op;
  logic        ext_op;
  logic [23:0] pm_base;
  logic [23:0] pm_inc;

  assign inc_op    = x.op inside {tbx_pkg::OP_LOAD_INC, tbx_pkg::OP_STORE_INC};
  assign dec_op    = x.op inside {tbx_pkg::OP_LOAD_DEC, tbx_pkg::OP_STORE_DEC};
  assign disp_op   = x.op inside {tbx_pkg::OP_LOAD_DISP, tbx_pkg::OP_STORE_DISP};
  assign ext_op    = x.op inside {tbx_pkg::OP_EPM_R0, tbx_pkg::OP_EPM_RD, tbx_pkg::OP_EPM_INC};
  // Extended reads put the page register above the pointer [RQ9]
  assign pm_base   = {(ext_op ? x.page_ext : 8'h00), x.ptr_val};
  assign pm_inc    = 24'(pm_base + 24'h000001);
  assign x.pm_addr = pm_base;
  // Pre-decrement addresses the new value, displacement leaves it alone [RQ3] [RQ4] [RQ6]
  assign x.eff_addr = dec_op  ? 16'(x.ptr_val - 16'h0001) :
                      disp_op ? 16'(x.ptr_val + {10'h000, x.disp}) : x.ptr_val;
  // Post-increment after access; extended form steps all 24 bits [RQ2] [RQ5] [RQ8] [RQ9]
  assign x.ptr_next = dec_op ? 16'(x.ptr_val - 16'h0001) :
                      inc_op ? 16'(x.ptr_val + 16'h0001) : pm_inc[15:0];
  assign x.ptr_wr    = inc_op | dec_op | (x.op inside {tbx_pkg::OP_PM_INC, tbx_pkg::OP_EPM_INC});
  assign x.page_wr   = x.op == tbx_pkg::OP_EPM_INC;
  assign x.page_next = pm_inc[23:16];
  // First pair has no displaced form [RQ4]
  assign x.bad_ptr   = (x.ptr_sel == 2'h3) | (disp_op & (x.ptr_sel == tbx_pkg::PTR_X));
endmodule : tbx_addr_gen

/* verilog/tbx_flag_unit.sv */
`timescale 1ns/100ps
module tbx_flag_unit (
  // Operand, flags and results
  tbx_exec_if.flag_mp x
);
  logic rot;
  logic cout;

  always_comb begin
    x.alu_res    = x.opnd;
    x.flags_next = x.flags;
    x.res_wr     = 1'b0;
    x.br_take    = 1'b0;
    rot          = 1'b0;
    cout         = 1'b0;
    case (x.op)
      tbx_pkg::OP_BR_INT_ON: begin
        x.br_take = x.flags[tbx_pkg::FLG_I]; // [RQ1]
      end
      tbx_pkg::OP_BR_INT_OFF: begin
        x.br_take = ~x.flags[tbx_pkg::FLG_I]; // [RQ1]
      end
      tbx_pkg::OP_ROT_LEFT: begin
        x.alu_res = {x.opnd[6:0], x.flags[tbx_pkg::FLG_C]}; // [RQ12]
        cout      = x.opnd[7];
        rot       = 1'b1;
      end
      tbx_pkg::OP_ROT_RIGHT: begin
        x.alu_res = {x.flags[tbx_pkg::FLG_C], x.opnd[7:1]}; // [RQ13]
        cout      = x.opnd[0];
        rot       = 1'b1;
      end
      tbx_pkg::OP_BIT_TO_T: begin
        x.flags_next[tbx_pkg::FLG_T] = x.opnd[x.bit_sel]; // [RQ14]
      end
      tbx_pkg::OP_T_TO_BIT: begin
        x.alu_res[x.bit_sel] = x.flags[tbx_pkg::FLG_T]; // [RQ15]
        x.res_wr             = 1'b1;
      end
      tbx_pkg::OP_FLAG_SET: begin
        x.flags_next[x.bit_sel] = 1'b1; // [RQ16]
      end
      tbx_pkg::OP_FLAG_CLR: begin
        x.flags_next[x.bit_sel] = 1'b0; // [RQ16]
      end
      default: begin
        x.res_wr = 1'b0;
      end
    endcase
    // Rotates update zero, carry, negative and overflow [RQ12] [RQ13]
    if (rot) begin
      x.flags_next[tbx_pkg::FLG_C] = cout;
      x.flags_next[tbx_pkg::FLG_N] = x.alu_res[7];
      x.flags_next[tbx_pkg::FLG_Z] = x.alu_res == 8'h00;
      x.flags_next[tbx_pkg::FLG_V] = x.alu_res[7] ^ cout;
      x.res_wr                     = 1'b1;
    end
  end
endmodule : tbx_flag_unit

/* verilog/tbx_exec_core.sv */
`timescale 1ns/100ps
// Summary of operation
// RQ1: Branch on interrupt flag set or clear; 1 cycle untaken, 2 taken, target pc+k+1.
// RQ2: Post-increment load reads at pointer, then bumps pointer; 2 cycles, flags kept.
// RQ3: Pre-decrement load drops pointer first, reads at new value; 2 cycles.
// RQ4: Displaced load reads Y or Z plus unsigned offset, pointer kept; 2 cycles.
// RQ5: Indirect stores mirror load variants and ordering; 2 cycles, flags kept.
// RQ6: Displaced store writes at Y or Z plus offset, pointer kept; 2 cycles.
// RQ7: Direct load and store use a full address word; 2 cycles each.
// RQ8: Program memory read at Z, implicit destination register zero, optional increment; 3 cycles.
// RQ9: Extended read prefixes page register; increment steps the whole 24-bit value; 3 cycles.
// RQ10: Push and pop move one byte via the stack; 2 cycles, flags kept.
// RQ11: I/O bit set and clear force one bit of an I/O register; 2 cycles.
// RQ12: Rotate left through carry; updates Z, C, N, V in 1 cycle.
// RQ13: Rotate right through carry; updates Z, C, N, V in 1 cycle.
// RQ14: Copy a register bit into T, only T changes; 1 cycle.
// RQ15: Copy T into a register bit, flags unchanged; 1 cycle.
// RQ16: Each status flag has its own set and clear; 1 cycle, only that flag.
// RQ17: Debug break does nothing in normal execution.
// RQ18: Pointer pairs live in the register file; updates are register writes.
module tbx_exec_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Instruction command
  input  wire logic                cmd_valid,
  input  wire tbx_pkg::tbx_op_type cmd_op,
  input  wire logic [4:0]          cmd_rd,
  input  wire logic [1:0]          cmd_ptr,
  input  wire logic [5:0]          cmd_disp,
  input  wire logic [15:0]         cmd_addr,
  input  wire logic [2:0]          cmd_bit,
  input  wire logic [4:0]          cmd_io,
  input  wire logic [15:0]         cmd_pc,
  input  wire logic [6:0]          cmd_offs,
  output logic                     cmd_ready_q,
  output logic                     done_q,
  output logic                     bad_q,
  output logic                     brk_q,
  output logic                     pc_load_q,
  output logic [15:0]              pc_target_q,
  // Data space
  output logic [15:0]              dm_addr_q,
  output logic [7:0]               dm_wdata_q,
  output logic                     dm_re_q,
  output logic                     dm_we_q,
  input  wire logic [7:0]          dm_rdata,
  // I/O registers
  output logic [4:0]               io_addr_q,
  output logic [7:0]               io_wdata_q,
  output logic                     io_re_q,
  output logic                     io_we_q,
  input  wire logic [7:0]          io_rdata,
  // Program memory
  output logic [23:0]              pm_addr_q,
  output logic                     pm_re_q,
  input  wire logic [7:0]          pm_rdata,
  // Register file access
  input  wire logic                rf_we,
  input  wire logic [4:0]          rf_waddr,
  input  wire logic [7:0]          rf_wdata,
  input  wire logic [4:0]          rf_raddr,
  output logic [7:0]               rf_rdata_q,
  // Core state
  input  wire logic                pext_we,
  input  wire logic [7:0]          pext_wdata,
  output logic [7:0]               status_flags_q,
  output logic [7:0]               page_ext_q,
  output logic [15:0]              sp_q
);
  tbx_pkg::tbx_state_type state_q;
  tbx_pkg::tbx_state_type state_d;
  logic [7:0]  rf_q [32];
  logic [4:0]  rd_q;
  logic [2:0]  iobit_q;
  logic        ld_q;
  logic        pm_q;
  logic        io_q;
  logic        ioset_q;
  logic        br_q;
  logic        accept;
  logic        go;
  logic        br_op;
  logic        pm_op;
  logic        io_op;
  logic        ld_op;
  logic        st_op;
  logic [1:0]  cyc;
  logic        fin;
  logic [4:0]  ptr_lo;
  logic [4:0]  ptr_hi;
  logic        one_wr;
  logic        ld_wr;
  logic        res_en;
  logic [4:0]  res_idx;
  logic [7:0]  res_val;
  logic        ptr_en;
  logic [15:0] br_tgt;
  logic [15:0] dm_addr_d;
  logic [7:0]  io_mask;

  tbx_exec_if xif ();

  // Operand selection
  assign pm_op       = tbx_pkg::is_pm(cmd_op);
  assign xif.op      = cmd_op;
  assign xif.ptr_sel = pm_op ? tbx_pkg::PTR_Z : cmd_ptr; // [RQ8]
  assign xif.disp    = cmd_disp;
  assign ptr_lo      = 5'(tbx_pkg::PTR_BASE + {2'b00, xif.ptr_sel, 1'b0});
  assign ptr_hi      = ptr_lo | 5'h01;
  assign xif.ptr_val = {rf_q[ptr_hi], rf_q[ptr_lo]}; // [RQ18]
  assign xif.page_ext = page_ext_q;
  assign xif.flags   = status_flags_q;
  assign xif.opnd    = rf_q[cmd_rd];
  assign xif.bit_sel = cmd_bit;

  tbx_addr_gen  u_addr (.x(xif.addr_mp));
  tbx_flag_unit u_flag (.x(xif.flag_mp));

  // Command decode
  assign accept = cmd_valid & cmd_ready_q;
  assign go     = accept & ~xif.bad_ptr;
  assign cyc    = tbx_pkg::op_cycles(cmd_op);
  assign br_op  = cmd_op inside {tbx_pkg::OP_BR_INT_ON, tbx_pkg::OP_BR_INT_OFF};
  assign io_op  = cmd_op inside {tbx_pkg::OP_IO_SET, tbx_pkg::OP_IO_CLR};
  assign ld_op  = pm_op | (cmd_op inside {[tbx_pkg::OP_LOAD_IND:tbx_pkg::OP_LOAD_DIR],
                                          tbx_pkg::OP_POP});
  assign st_op  = cmd_op inside {[tbx_pkg::OP_STORE_IND:tbx_pkg::OP_STORE_DIR],
                                 tbx_pkg::OP_PUSH};
  assign fin    = state_q == tbx_pkg::S_FIN;
  assign br_tgt = 16'(cmd_pc + {{9{cmd_offs[6]}}, cmd_offs} + 16'h0001); // [RQ1]

  // Data space address: direct word, stack or pointer path
  assign dm_addr_d = (cmd_op inside {tbx_pkg::OP_LOAD_DIR, tbx_pkg::OP_STORE_DIR}) ? cmd_addr :
                     (cmd_op == tbx_pkg::OP_PUSH) ? sp_q :
                     (cmd_op == tbx_pkg::OP_POP)  ? 16'(sp_q + 16'h0001) : xif.eff_addr;

  // Register file write sources
  assign one_wr  = go & (cyc == tbx_pkg::CYC_ONE) & xif.res_wr;
  assign ld_wr   = fin & ld_q;
  assign res_en  = one_wr | ld_wr;
  assign res_idx = ld_wr ? rd_q : cmd_rd;
  assign res_val = ld_wr ? (pm_q ? pm_rdata : dm_rdata) : xif.alu_res;
  assign ptr_en  = go & xif.ptr_wr; // [RQ18]
  assign io_mask = 8'h01 << iobit_q;

  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tbx_pkg::S_IDLE: begin
        if (go && cyc == tbx_pkg::CYC_THREE) begin
          state_d = tbx_pkg::S_HOLD; // [RQ8] [RQ9]
        end else if (go && (cyc == tbx_pkg::CYC_TWO || (br_op && xif.br_take))) begin
          state_d = tbx_pkg::S_FIN; // [RQ1]
        end
      end
      tbx_pkg::S_HOLD: begin
        state_d = tbx_pkg::S_FIN;
      end
      tbx_pkg::S_FIN: begin
        state_d = tbx_pkg::S_IDLE;
      end
      default: begin
        state_d = tbx_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= tbx_pkg::S_IDLE;
      cmd_ready_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      cmd_ready_q <= state_d == tbx_pkg::S_IDLE;
    end
  end

  // Completion and event pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q    <= 1'b0;
      bad_q     <= 1'b0;
      brk_q     <= 1'b0;
      pc_load_q <= 1'b0;
    end else begin
      done_q    <= fin | (accept & xif.bad_ptr) |
                   (go & (cyc == tbx_pkg::CYC_ONE) & ~(br_op & xif.br_take));
      bad_q     <= accept & xif.bad_ptr;
      brk_q     <= go & (cmd_op == tbx_pkg::OP_BRK); // [RQ17]
      pc_load_q <= fin & br_q; // [RQ1]
    end
  end

  // Operation context held across cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q        <= 5'h00;
      iobit_q     <= 3'h0;
      {ld_q, pm_q, io_q, ioset_q, br_q} <= 5'h00;
      pc_target_q <= 16'h0000;
    end else if (go) begin
      rd_q        <= (cmd_op inside {tbx_pkg::OP_PM_R0, tbx_pkg::OP_EPM_R0}) ? 5'h00 : cmd_rd; // [RQ8]
      iobit_q     <= cmd_bit;
      {ld_q, pm_q, io_q} <= {ld_op, pm_op, io_op};
      ioset_q     <= cmd_op == tbx_pkg::OP_IO_SET;
      br_q        <= br_op & xif.br_take;
      pc_target_q <= br_tgt; // [RQ1]
    end
  end

  // Data space port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= 8'h00;
      dm_re_q    <= 1'b0;
      dm_we_q    <= 1'b0;
    end else begin
      dm_re_q <= go & ld_op & ~pm_op; // [RQ2] [RQ3] [RQ4] [RQ7] [RQ10]
      dm_we_q <= go & st_op; // [RQ5] [RQ6] [RQ7] [RQ10]
      if (go) begin
        dm_addr_q  <= dm_addr_d;
        dm_wdata_q <= xif.opnd;
      end
    end
  end

  // Program memory port, held two cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pm_addr_q <= 24'h000000;
      pm_re_q   <= 1'b0;
    end else begin
      pm_re_q <= (go & pm_op) | (pm_re_q & (state_q == tbx_pkg::S_HOLD)); // [RQ8] [RQ9]
      if (go && pm_op) begin
        pm_addr_q <= xif.pm_addr;
      end
    end
  end

  // I/O read-modify-write of one bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_addr_q  <= 5'h00;
      io_wdata_q <= 8'h00;
      io_re_q    <= 1'b0;
      io_we_q    <= 1'b0;
    end else begin
      io_re_q <= go & io_op;
      io_we_q <= fin & io_q; // [RQ11]
      if (go && io_op) begin
        io_addr_q <= cmd_io;
      end
      if (fin && io_q) begin
        io_wdata_q <= ioset_q ? (io_rdata | io_mask) : (io_rdata & ~io_mask); // [RQ11]
      end
    end
  end

  // Stack pointer, page register and status flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_q           <= tbx_pkg::SP_RST;
      page_ext_q     <= tbx_pkg::PEXT_RST;
      status_flags_q <= tbx_pkg::FLAGS_RST;
    end else begin
      if (go && cmd_op == tbx_pkg::OP_PUSH) begin
        sp_q <= 16'(sp_q - 16'h0001); // [RQ10]
      end else if (go && cmd_op == tbx_pkg::OP_POP) begin
        sp_q <= 16'(sp_q + 16'h0001); // [RQ10]
      end
      if (go && xif.page_wr) begin
        page_ext_q <= xif.page_next; // [RQ9]
      end else if (pext_we) begin
        page_ext_q <= pext_wdata;
      end
      if (go && cyc == tbx_pkg::CYC_ONE) begin
        status_flags_q <= xif.flags_next; // [RQ12] [RQ13] [RQ14] [RQ16]
      end
    end
  end

  // Register file; results beat pointer updates, then external writes
  for (genvar gi = 0; gi < 32; gi++) begin : g_rf
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rf_q[gi] <= tbx_pkg::RF_RST;
      end else if (res_en && res_idx == 5'(gi)) begin
        rf_q[gi] <= res_val; // [RQ2] [RQ12] [RQ15]
      end else if (ptr_en && ptr_lo == 5'(gi)) begin
        rf_q[gi] <= xif.ptr_next[7:0]; // [RQ18]
      end else if (ptr_en && ptr_hi == 5'(gi)) begin
        rf_q[gi] <= xif.ptr_next[15:8]; // [RQ18]
      end else if (rf_we && rf_waddr == 5'(gi)) begin
        rf_q[gi] <= rf_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rf_rdata_q <= 8'h00;
    end else begin
      rf_rdata_q <= rf_q[rf_raddr];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_branch_untaken: assert property (go && br_op && !xif.br_take |=> done_q && !pc_load_q) // [RQ1]
    else $error("untaken branch not done in one cycle");
  chk_branch_taken: assert property (go && br_op && xif.br_take |=> // [RQ1]
    (pc_target_q == $past(br_tgt)) && !done_q ##1 (pc_load_q && done_q))
    else $error("taken branch timing or target wrong");
  chk_postinc_ptr: assert property (go && cmd_op == tbx_pkg::OP_LOAD_INC && !cmd_rd[4] |=> // [RQ2]
    dm_addr_q == $past(xif.ptr_val) && {rf_q[$past(ptr_hi)], rf_q[$past(ptr_lo)]} ==
    16'($past(xif.ptr_val) + 16'h0001))
    else $error("post-increment address or pointer wrong");
  chk_predec_addr: assert property (go && cmd_op inside {tbx_pkg::OP_LOAD_DEC, // [RQ3] [RQ5]
    tbx_pkg::OP_STORE_DEC} |=> dm_addr_q == 16'($past(xif.ptr_val) - 16'h0001))
    else $error("pre-decrement address wrong");
  chk_disp_addr: assert property (go && cmd_op inside {tbx_pkg::OP_LOAD_DISP, // [RQ4] [RQ6]
    tbx_pkg::OP_STORE_DISP} |=> dm_addr_q == 16'($past(xif.ptr_val) + {10'h000, $past(cmd_disp)}))
    else $error("displaced address wrong");
  chk_two_cycle: assert property (go && cyc == tbx_pkg::CYC_TWO |=> // [RQ7] [RQ10] [RQ11]
    !cmd_ready_q && !done_q ##1 cmd_ready_q && done_q)
    else $error("two-cycle operation timing wrong");
  chk_pm_three: assert property (go && pm_op |=> (!cmd_ready_q && pm_re_q)[*2] // [RQ8]
    ##1 (done_q && cmd_ready_q))
    else $error("program memory read timing wrong");
  chk_ext_inc: assert property (go && cmd_op == tbx_pkg::OP_EPM_INC |=> // [RQ9]
    {page_ext_q, rf_q[31], rf_q[30]} == 24'($past(xif.pm_addr) + 24'h000001))
    else $error("extended increment wrong");
  chk_io_bit: assert property (fin && io_q |=> io_we_q && // [RQ11]
    io_wdata_q[$past(iobit_q)] == $past(ioset_q))
    else $error("io bit value wrong");
  chk_rot_carry: assert property (go && cmd_op inside {tbx_pkg::OP_ROT_LEFT, // [RQ12] [RQ13]
    tbx_pkg::OP_ROT_RIGHT} |=> status_flags_q[tbx_pkg::FLG_C] ==
    $past(cmd_op == tbx_pkg::OP_ROT_LEFT ? xif.opnd[7] : xif.opnd[0]))
    else $error("rotate carry wrong");
  chk_t_only: assert property (go && cmd_op == tbx_pkg::OP_BIT_TO_T |=> // [RQ14]
    status_flags_q == {$past(status_flags_q[7]), $past(xif.opnd[cmd_bit]),
    $past(status_flags_q[5:0])})
    else $error("bit to T changed other flags");
  chk_flags_kept: assert property (go && (cyc != tbx_pkg::CYC_ONE || // [RQ2] [RQ15]
    cmd_op == tbx_pkg::OP_T_TO_BIT) |=> $stable(status_flags_q))
    else $error("multi-cycle operation changed flags");
  chk_flag_single: assert property (go && cmd_op == tbx_pkg::OP_FLAG_SET |=> // [RQ16]
    status_flags_q == ($past(status_flags_q) | (8'h01 << $past(cmd_bit))))
    else $error("flag set touched other flags");

  cov_branch_taken: cover property (go && br_op && xif.br_take ##2 pc_load_q);
  cov_ext_inc: cover property (go && cmd_op == tbx_pkg::OP_EPM_INC ##3 done_q);
  cov_io_set: cover property (fin && io_q && ioset_q);
  cov_bad_ptr: cover property (bad_q);
endmodule : tbx_exec_core

/* verification/tbx_mem_model.sv */
`timescale 1ns/100ps
module tbx_mem_model (
  // Clock
  input  wire logic        clk,
  // Data space
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_re,
  input  wire logic        dm_we,
  output logic [7:0]       dm_rdata,
  // I/O registers
  input  wire logic [4:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_re,
  input  wire logic        io_we,
  output logic [7:0]       io_rdata,
  // Program memory
  input  wire logic [23:0] pm_addr,
  input  wire logic        pm_re,
  output logic [7:0]       pm_rdata
);
  logic [7:0] dm [0:65535];
  logic [7:0] io [0:31];
  logic [7:0] junk_q = 8'h55;
  logic       pm_re_q = 1'b0;
  initial begin
    for (int i = 0; i < 65536; i++) dm[i] = i[7:0] ^ 8'hA5;
    for (int i = 0; i < 32; i++) io[i] = 8'h00;
  end
  // Idle lines toggle
  assign dm_rdata = dm_re ? dm[dm_addr] : junk_q;
  assign io_rdata = io_re ? io[io_addr] : junk_q;
  // Byte valid in second read cycle
  assign pm_rdata = (pm_re && pm_re_q) ? pm_addr[7:0] ^ pm_addr[15:8] ^ pm_addr[23:16] ^ 8'h3C
                                       : junk_q;
  always @(posedge clk) begin
    junk_q <= ~junk_q;
    pm_re_q <= pm_re;
    if (dm_we) dm[dm_addr] <= dm_wdata;
    if (io_we) io[io_addr] <= io_wdata;
  end
endmodule : tbx_mem_model

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, sys_rst = 1, cmd_valid = 0, rf_we = 0, pext_we = 0, bad, ld;
  tbx_pkg::tbx_op_type cmd_op = tbx_pkg::OP_NOP;
  logic [4:0] cmd_rd = 0, cmd_io = 0, rf_waddr = 0, rf_raddr = 0, io_addr_q;
  logic [1:0] cmd_ptr = 0;
  logic [5:0] cmd_disp = 0;
  logic [15:0] cmd_addr = 0, cmd_pc = 16'h0100, pc_target_q, dm_addr_q, sp_q;
  logic [2:0] cmd_bit = 0;
  logic [6:0] cmd_offs = 0;
  logic [7:0] rf_wdata = 0, pext_wdata = 0, dm_wdata_q, dm_rdata, io_wdata_q, io_rdata;
  logic [7:0] pm_rdata, rf_rdata_q, status_flags_q, page_ext_q;
  logic cmd_ready_q, done_q, bad_q, brk_q, pc_load_q, dm_re_q, dm_we_q, io_re_q, io_we_q, pm_re_q;
  logic [23:0] pm_addr_q;
  int error_cnt = 0, compares = 0, cyc;
  tbx_exec_core tbx_exec_core_inst (.clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_rd, .cmd_ptr,
    .cmd_disp, .cmd_addr, .cmd_bit, .cmd_io, .cmd_pc, .cmd_offs, .cmd_ready_q, .done_q, .bad_q,
    .brk_q, .pc_load_q, .pc_target_q, .dm_addr_q, .dm_wdata_q, .dm_re_q, .dm_we_q, .dm_rdata,
    .io_addr_q, .io_wdata_q, .io_re_q, .io_we_q, .io_rdata, .pm_addr_q, .pm_re_q, .pm_rdata,
    .rf_we, .rf_waddr, .rf_wdata, .rf_raddr, .rf_rdata_q, .pext_we, .pext_wdata,
    .status_flags_q, .page_ext_q, .sp_q);
  tbx_mem_model tbx_mem_model_inst (.clk, .dm_addr(dm_addr_q), .dm_wdata(dm_wdata_q),
    .dm_re(dm_re_q), .dm_we(dm_we_q), .dm_rdata(dm_rdata), .io_addr(io_addr_q),
    .io_wdata(io_wdata_q), .io_re(io_re_q), .io_we(io_we_q), .io_rdata(io_rdata),
    .pm_addr(pm_addr_q), .pm_re(pm_re_q), .pm_rdata(pm_rdata));
  always #12.5 clk = ~clk;
  task automatic stop_test;
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] r, input logic [7:0] v);
    @(negedge clk);
    rf_we = 1;
    rf_waddr = r;
    rf_wdata = v;
    @(negedge clk);
    rf_we = 0;
  endtask : wr
  task automatic rck(input string n, input logic [4:0] r, input logic [7:0] e);
    @(negedge clk);
    rf_raddr = r;
    @(negedge clk);
    chk(n, e, rf_rdata_q);
  endtask : rck
  task automatic wp(input logic [4:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 5'h01, v[15:8]);
  endtask : wp
  task automatic run(input tbx_pkg::tbx_op_type op, input logic [4:0] r, input logic [1:0] p,
                     input logic [15:0] a, input logic [2:0] b);
    @(negedge clk);
    cmd_valid = 1;
    cmd_op = op;
    cmd_rd = r;
    cmd_ptr = p;
    cmd_addr = a;
    cmd_disp = a[5:0];
    cmd_io = a[4:0];
    cmd_offs = a[6:0];
    cmd_bit = b;
    @(negedge clk);
    cmd_valid = 0;
    cyc = 1;
    while (done_q !== 1'b1) begin
      @(negedge clk);
      cyc++;
    end
    bad = bad_q;
    ld = pc_load_q;
  endtask : run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 0;
    chk("rst", 24'h0FFF, sp_q);
    chk("rst", 24'h000001, {page_ext_q, status_flags_q, 7'h00, cmd_ready_q});
    for (int i = 0; i < 8; i++) begin
      run(tbx_pkg::OP_FLAG_SET, 0, 0, 0, i[2:0]);
      chk("fset", {8'h01, 8'hFF >> (7 - i)}, {cyc[7:0], status_flags_q});
    end
    for (int i = 0; i < 8; i++) begin
      run(tbx_pkg::OP_FLAG_CLR, 0, 0, 0, i[2:0]);
      chk("fclr", 8'(8'hFE << i), status_flags_q);
    end
    for (int j = 0; j < 2; j++) begin
      run(j ? tbx_pkg::OP_FLAG_SET : tbx_pkg::OP_FLAG_CLR, 0, 0, 0, 3'h7);
      run(tbx_pkg::OP_BR_INT_ON, 0, 0, 16'h007E, 0);
      chk("on", {j[0], 8'(1 + j)}, {ld, cyc[7:0]});
      if (j) chk("tgt", 16'h00FF, pc_target_q);
      run(tbx_pkg::OP_BR_INT_OFF, 0, 0, 16'h0005, 0);
      chk("off", {~j[0], 8'(2 - j)}, {ld, cyc[7:0]});
      if (!j) chk("tgt", 16'h0106, pc_target_q);
    end
    wp(26, 16'h0200);
    run(tbx_pkg::OP_LOAD_INC, 5, 0, 0, 0);
    chk("cyc", 2, cyc);
    rck("ldinc", 5, 8'hA5);
    rck("xinc", 26, 8'h01);
    wp(28, 16'h0300);
    run(tbx_pkg::OP_LOAD_DEC, 6, 1, 0, 0);
    rck("lddec", 6, 8'h5A);
    rck("ydec", 29, 8'h02);
    wp(30, 16'h0400);
    run(tbx_pkg::OP_LOAD_DISP, 7, 2, 16'h003F, 0);
    rck("lddsp", 7, 8'h9A);
    rck("zkeep", 30, 8'h00);
    run(tbx_pkg::OP_LOAD_DISP, 7, 0, 16'h0001, 0);
    chk("xdisp", 1, bad);
    run(tbx_pkg::OP_LOAD_DIR, 8, 0, 16'h0123, 0);
    rck("lddir", 8, 8'h86);
    run(tbx_pkg::OP_STORE_INC, 5, 0, 0, 0);
    rck("xinc", 26, 8'h02);
    run(tbx_pkg::OP_STORE_DEC, 6, 1, 0, 0);
    run(tbx_pkg::OP_STORE_DISP, 7, 1, 16'h0010, 0);
    run(tbx_pkg::OP_STORE_DIR, 8, 0, 16'h0777, 0);
    chk("cyc", 2, cyc);
    chk("stinc", 8'hA5, tbx_mem_model_inst.dm[16'h0201]);
    chk("stdec", 8'h5A, tbx_mem_model_inst.dm[16'h02FE]);
    chk("stdsp", 8'h9A, tbx_mem_model_inst.dm[16'h030E]);
    chk("stdir", 8'h86, tbx_mem_model_inst.dm[16'h0777]);
    @(negedge clk);
    pext_we = 1;
    pext_wdata = 8'h01;
    @(negedge clk);
    pext_we = 0;
    run(tbx_pkg::OP_EPM_INC, 9, 0, 0, 0);
    chk("cyc", 3, cyc);
    rck("epm", 9, 8'h39);
    wp(30, 16'hFFFF);
    run(tbx_pkg::OP_EPM_INC, 9, 0, 0, 0);
    rck("epm", 9, 8'h3D);
    chk("page", 8'h02, page_ext_q);
    rck("zwrap", 31, 8'h00);
    run(tbx_pkg::OP_PM_R0, 9, 0, 0, 0);
    rck("pmr0", 0, 8'h3C);
    run(tbx_pkg::OP_EPM_RD, 10, 0, 0, 0);
    rck("epmrd", 10, 8'h3E);
    run(tbx_pkg::OP_PUSH, 5, 0, 0, 0);
    chk("push", {8'hA5, 16'h0FFE}, {tbx_mem_model_inst.dm[16'h0FFF], sp_q});
    run(tbx_pkg::OP_POP, 11, 0, 0, 0);
    chk("pop", {8'h02, 16'h0FFF}, {cyc[7:0], sp_q});
    rck("pop", 11, 8'hA5);
    run(tbx_pkg::OP_IO_SET, 0, 0, 16'h0005, 3'h3);
    run(tbx_pkg::OP_IO_SET, 0, 0, 16'h0005, 3'h0);
    run(tbx_pkg::OP_IO_CLR, 0, 0, 16'h0005, 3'h3);
    @(negedge clk);
    chk("io", {8'h02, 8'h01}, {cyc[7:0], tbx_mem_model_inst.io[5]});
    wr(12, 8'h81);
    run(tbx_pkg::OP_FLAG_SET, 0, 0, 0, 3'h0);
    run(tbx_pkg::OP_ROT_LEFT, 12, 0, 0, 0);
    chk("rolc", 1, status_flags_q[0]);
    rck("rol", 12, 8'h03);
    run(tbx_pkg::OP_ROT_RIGHT, 12, 0, 0, 0);
    chk("rorf", 4'h5, status_flags_q[3:0]);
    rck("ror", 12, 8'h81);
    run(tbx_pkg::OP_BIT_TO_T, 12, 0, 0, 3'h7);
    chk("tget", 1, status_flags_q[6]);
    run(tbx_pkg::OP_T_TO_BIT, 13, 0, 0, 3'h2);
    rck("tput", 13, 8'h04);
    run(tbx_pkg::OP_BRK, 0, 0, 0, 0);
    chk("brk", 1, brk_q);
    stop_test;
  end
endmodule : tb_top
